/* File: hbfp_pkg.sv */
// Constants, field layouts and state types of the half-bridge fault protection block.
package hbfp_pkg;

	// ---------------------------------------------------------------
	// Sizes and timing
	// ---------------------------------------------------------------
	localparam int NB              = 6;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int OC_DELAY_NS     = 10000;
	localparam int ULD_DELAY_NS    = 350000;
	// Least times, so the cycle counts round up.
	localparam int OC_CYC          = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ULD_CYC         = (ULD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_CNT_W        = 7;
	localparam int ULD_CNT_W       = 12;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_CMD    = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_BSTAT  = 4'h8;
	localparam logic [3:0] OFS_FAULT  = 4'hC;

	// ---------------------------------------------------------------
	// Command word, status frame and fault word fields
	// ---------------------------------------------------------------
	localparam int CMD_OVERVOLTAGE_LOCKOUT_ENABLE    = 0;
	localparam int CMD_EN_LSB  = 1;
	localparam int CMD_CFG_LSB = 7;
	localparam int CMD_UNDERLOAD_SHUTDOWN_CONTROL   = 13;
	localparam int CMD_SRR     = 15;
	localparam int FR_TW       = 0;
	localparam int FR_CFG_LSB  = 1;
	localparam int FR_EN_LSB   = 7;
	localparam int FR_ULD      = 13;
	localparam int FR_PSF      = 14;
	localparam int FR_OCS      = 15;
	localparam int FLT_TSD_LSB = 0;
	localparam int FLT_OC_LSB  = 8;
	localparam int FLT_ULD_LSB = 16;
	localparam int FLT_OFF_LSB = 24;

	// Two-bit bridge status codes.
	localparam logic [1:0] BS_OK  = 2'h0;
	localparam logic [1:0] BS_OC  = 2'h1;
	localparam logic [1:0] BS_ULD = 2'h2;
	localparam logic [1:0] BS_TSD = 2'h3;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} hbfp_bus_t;

	typedef struct packed {
		logic          ov;
		logic [NB-1:0] oc;
		logic [NB-1:0] underload_flag;
		logic [NB-1:0] tw;
		logic [NB-1:0] tsd;
	} hbfp_sense_t;

	typedef struct packed {
		hbfp_bus_t                    bus;
		logic [31:0]                  rdata;
		logic                         overvoltage_lockout_enable;
		logic                         underload_shutdown_control;
		logic [NB-1:0]                en;
		logic [NB-1:0]                cfg;
		logic [NB-1:0]                oc_lat;
		logic [NB-1:0]                uld_lat;
		logic [NB-1:0]                uld_off;
		logic [NB-1:0]                tsd_lat;
		logic [NB-1:0][OC_CNT_W-1:0]  oc_cnt;
		logic [ULD_CNT_W-1:0]         uld_cnt;
		logic                         supply_fail_flag;
		logic                         tw;
		logic [NB-1:0]                hs;
		logic [NB-1:0]                ls;
		logic                         cs_n_d;
		logic                         sclk_d;
		logic                         tsd_win;
	} hbfp_state_t;

endpackage

/* File: hbfp_core.sv */
// Half-bridge fault protection: fault latches, driver gating and Avalon-MM register slave.
// Functional notes
// - Driver supply overvoltage sets the supply fail flag at frame bit 14.
// - With lockout enable set, overvoltage turns every output off until it ends.
// - During overvoltage lockout the programmed driver states stay stored.
// - After overvoltage ends, programmed outputs come back on by themselves.
// - With lockout enable clear, overvoltage leaves outputs alone; flag still reports.
// - Supply fail flag follows the supply and clears by itself.
// - Overcurrent held for the delay time latches both switches of that output off.
// - Overcurrent sets global flag bit 15 and bridge status code 01.
// - Overcurrent latch clears only by a later command with reset request set, by enable pin low or by power-on reset.
// - Low-side current under threshold past the delay sets the global underload flag.
// - With underload shutdown control set, underload latches that bridge off.
// - One shared underload timer; later underloads wait only the remainder.
// - Underload flag and underload shutdown hold until a reset request command.
// - Underload shows at frame bit 13 and as bridge status code 10.
// - Thermal warning sets frame bit 0 and drivers keep running.
// - Thermal warning flag clears by itself once temperature drops.
// - Each bridge has its own thermal shutdown latch switching only it off.
// - Thermal shutdown clears on reset request only once temperature is below trip.
// - Enable pin low or power-on reset also clears every latched fault.
// - A fault latch-off zeroes that bridge's enable and configuration bits.
// - Latched thermal shutdown drives serial out from select fall to first clock rise.
`timescale 1ns/1ps

module hbfp_core (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	input  wire hbfp_pkg::hbfp_sense_t  sense,
	input  wire logic                   enable_pin,
	input  wire logic                   chip_select_n,
	input  wire logic                   serial_clk,
	output logic                        tsd_so_out,
	output logic                        tsd_so_oe,
	output logic      [5:0]             hs_on,
	output logic      [5:0]             ls_on
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------

	// Register select, shared by the read and the write path.
	function automatic logic [2:0] reg_sel(input logic [3:0] addr);
		unique case (addr)
			hbfp_pkg::OFS_CMD:    reg_sel = 3'h1;
			hbfp_pkg::OFS_STATUS: reg_sel = 3'h2;
			hbfp_pkg::OFS_BSTAT:  reg_sel = 3'h3;
			hbfp_pkg::OFS_FAULT:  reg_sel = 3'h4;
			default:              reg_sel = 3'h0;
		endcase
	endfunction

	// Command word as software reads it back; the reset request never reads as one.
	function automatic logic [15:0] pack_cmd(input hbfp_pkg::hbfp_state_t st);
		logic [15:0] w;
		w = 16'h0000;
		w[hbfp_pkg::CMD_OVERVOLTAGE_LOCKOUT_ENABLE] = st.overvoltage_lockout_enable;
		w[hbfp_pkg::CMD_EN_LSB +: hbfp_pkg::NB] = st.en;
		w[hbfp_pkg::CMD_CFG_LSB +: hbfp_pkg::NB] = st.cfg;
		w[hbfp_pkg::CMD_UNDERLOAD_SHUTDOWN_CONTROL] = st.underload_shutdown_control;
		return w;
	endfunction

	// ---------------------------------------------------------------
	// State and decoded terms
	// ---------------------------------------------------------------
	hbfp_pkg::hbfp_state_t s_reg;
	hbfp_pkg::hbfp_state_t s_next;
	logic [15:0]           frame;
	logic [11:0]           bstat;
	logic [31:0]           fault_word;
	logic                  cmd_wr;
	logic                  status_reset_request;
	logic [15:0]           cmd_new;
	logic [15:0]           cmd_cur;
	logic [5:0]            uld_cond;
	logic                  uld_fire;
	logic [5:0]            off_now;
	logic                  ov_lock;

	// The write takes effect at the edge where waitrequest is low.
	assign cmd_wr  = (s_reg.bus == hbfp_pkg::BUS_ACK) && avs_write &&
	                 (reg_sel(avs_address) == 3'h1);
	assign status_reset_request     = cmd_wr && avs_byteenable[1] && avs_writedata[hbfp_pkg::CMD_SRR];
	// Current command word kept as a net, so single lanes can be merged into it.
	assign cmd_cur = pack_cmd(s_reg);
	assign cmd_new = {avs_byteenable[1] ? avs_writedata[15:8] : cmd_cur[15:8],
	                  avs_byteenable[0] ? avs_writedata[7:0]  : cmd_cur[7:0]};

	// Underload only counts on a bridge whose low side is actually driven.
	assign uld_cond = sense.underload_flag & s_reg.ls;
	assign uld_fire = (|uld_cond) &&
	                  (s_reg.uld_cnt >= hbfp_pkg::ULD_CNT_W'(hbfp_pkg::ULD_CYC - 1));
	assign ov_lock  = sense.ov && s_reg.overvoltage_lockout_enable;

	// Status frame, bridge status codes and a detailed fault view.
	always_comb begin
		frame = 16'h0000;
		frame[hbfp_pkg::FR_OCS] = |s_reg.oc_lat;
		frame[hbfp_pkg::FR_PSF] = s_reg.supply_fail_flag;
		frame[hbfp_pkg::FR_ULD] = |s_reg.uld_lat;
		frame[hbfp_pkg::FR_EN_LSB +: hbfp_pkg::NB] = s_reg.en;
		frame[hbfp_pkg::FR_CFG_LSB +: hbfp_pkg::NB] = s_reg.cfg;
		frame[hbfp_pkg::FR_TW] = s_reg.tw;
		for (int i = 0; i < hbfp_pkg::NB; i++) begin
			if (s_reg.oc_lat[i]) begin
				bstat[2*i +: 2] = hbfp_pkg::BS_OC;
			end else if (s_reg.uld_lat[i]) begin
				bstat[2*i +: 2] = hbfp_pkg::BS_ULD;
			end else if (s_reg.tsd_lat[i]) begin
				bstat[2*i +: 2] = hbfp_pkg::BS_TSD;
			end else begin
				bstat[2*i +: 2] = hbfp_pkg::BS_OK;
			end
		end
		fault_word = 32'h0000_0000;
		fault_word[hbfp_pkg::FLT_TSD_LSB +: hbfp_pkg::NB] = s_reg.tsd_lat;
		fault_word[hbfp_pkg::FLT_OC_LSB +: hbfp_pkg::NB]  = s_reg.oc_lat;
		fault_word[hbfp_pkg::FLT_ULD_LSB +: hbfp_pkg::NB] = s_reg.uld_lat;
		fault_word[hbfp_pkg::FLT_OFF_LSB +: hbfp_pkg::NB] = s_reg.uld_off;
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------

	// Every latch uses set-wins-over-clear, so a fault still present while the
	// reset request lands is caught again in the same cycle rather than lost.
	always_comb begin
		s_next = s_reg;
		off_now = 6'h00;

		// Bus phase: one wait cycle, then the answer.
		unique case (s_reg.bus)
			hbfp_pkg::BUS_IDLE: begin
				if (avs_read || avs_write) begin
					s_next.bus = hbfp_pkg::BUS_ACK;
				end
				unique case (reg_sel(avs_address))
					3'h1:    s_next.rdata = {16'h0000, pack_cmd(s_reg)};
					3'h2:    s_next.rdata = {16'h0000, frame};
					3'h3:    s_next.rdata = {20'h00000, bstat};
					3'h4:    s_next.rdata = fault_word;
					default: s_next.rdata = 32'h0000_0000;
				endcase
			end
			hbfp_pkg::BUS_ACK: begin
				s_next.bus = hbfp_pkg::BUS_IDLE;
			end
		endcase

		// A command write loads the control bits; they persist through lockouts.
		if (cmd_wr) begin
			s_next.overvoltage_lockout_enable  = cmd_new[hbfp_pkg::CMD_OVERVOLTAGE_LOCKOUT_ENABLE];
			s_next.underload_shutdown_control = cmd_new[hbfp_pkg::CMD_UNDERLOAD_SHUTDOWN_CONTROL];
			s_next.en    = cmd_new[hbfp_pkg::CMD_EN_LSB +: hbfp_pkg::NB];
			s_next.cfg   = cmd_new[hbfp_pkg::CMD_CFG_LSB +: hbfp_pkg::NB];
		end

		// Non-latching flags simply follow their comparators.
		s_next.supply_fail_flag = sense.ov;
		s_next.tw  = |sense.tw;

		// Shared underload timer: runs while any driven low side reports underload, so a
		// second underload only waits out what is left of the running count.
		if (|uld_cond) begin
			if (s_reg.uld_cnt < hbfp_pkg::ULD_CNT_W'(hbfp_pkg::ULD_CYC)) begin
				s_next.uld_cnt = s_reg.uld_cnt + 1'b1;
			end
		end else begin
			s_next.uld_cnt = '0;
		end

		for (int i = 0; i < hbfp_pkg::NB; i++) begin
			// Per-bridge overcurrent delay counter, saturating at the delay.
			if (sense.oc[i]) begin
				if (s_reg.oc_cnt[i] < hbfp_pkg::OC_CNT_W'(hbfp_pkg::OC_CYC)) begin
					s_next.oc_cnt[i] = s_reg.oc_cnt[i] + 1'b1;
				end
			end else begin
				s_next.oc_cnt[i] = '0;
			end

			// Clears first: reset request, or enable pin held low.
			if (status_reset_request || !enable_pin) begin
				s_next.oc_lat[i]  = 1'b0;
				s_next.uld_lat[i] = 1'b0;
				s_next.uld_off[i] = 1'b0;
				if (!sense.tsd[i] || !enable_pin) begin
					s_next.tsd_lat[i] = 1'b0;
				end
			end

			// Sets win over the clears above.
			if (sense.oc[i] &&
			    s_reg.oc_cnt[i] >= hbfp_pkg::OC_CNT_W'(hbfp_pkg::OC_CYC - 1)) begin
				s_next.oc_lat[i] = 1'b1;
				off_now[i] = 1'b1;
			end
			if (uld_fire && uld_cond[i]) begin
				s_next.uld_lat[i] = 1'b1;
				if (s_reg.underload_shutdown_control) begin
					s_next.uld_off[i] = 1'b1;
					off_now[i] = 1'b1;
				end
			end
			if (sense.tsd[i]) begin
				s_next.tsd_lat[i] = 1'b1;
				off_now[i] = 1'b1;
			end

			// A latch-off forgets the bridge's programming, even over a same-cycle write.
			if (off_now[i]) begin
				s_next.en[i]  = 1'b0;
				s_next.cfg[i] = 1'b0;
			end
		end

		// Gate drivers: high side when configured one, low side otherwise,
		// never both, and nothing while locked out or latched off.
		for (int i = 0; i < hbfp_pkg::NB; i++) begin
			if (s_next.en[i] && enable_pin && !ov_lock && !s_next.oc_lat[i] &&
			    !s_next.uld_off[i] && !s_next.tsd_lat[i]) begin
				s_next.hs[i] = s_next.cfg[i];
				s_next.ls[i] = !s_next.cfg[i];
			end else begin
				s_next.hs[i] = 1'b0;
				s_next.ls[i] = 1'b0;
			end
		end

		// Serial-out window for the latched thermal shutdown indication.
		s_next.cs_n_d = chip_select_n;
		s_next.sclk_d = serial_clk;
		if (chip_select_n || (serial_clk && !s_reg.sclk_d)) begin
			s_next.tsd_win = 1'b0;
		end else if (s_reg.cs_n_d && !chip_select_n) begin
			s_next.tsd_win = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------

	// Power-on reset clears every latch and leaves all drivers off.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.cs_n_d <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign avs_waitrequest = (avs_read || avs_write) && (s_reg.bus != hbfp_pkg::BUS_ACK);
	assign avs_readdata    = s_reg.rdata;
	assign hs_on           = s_reg.hs;
	assign ls_on           = s_reg.ls;
	assign tsd_so_oe       = s_reg.tsd_win;
	assign tsd_so_out      = s_reg.tsd_win && (|s_reg.tsd_lat);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_cs_fall;
		s_reg.cs_n_d && !chip_select_n;
	endsequence

	sequence s_quiet;
		enable_pin && !cmd_wr && (s_reg.oc_lat | s_reg.uld_off | s_reg.tsd_lat) == 6'h00;
	endsequence

	property p_psf_follows;
		sense.ov |=> frame[hbfp_pkg::FR_PSF] ##1 (frame[hbfp_pkg::FR_PSF] == $past(sense.ov));
	endproperty
	a_psf_follows: assert property (p_psf_follows) else $error("supply fail flag wrong");

	property p_ov_lockout;
		(sense.ov && s_reg.overvoltage_lockout_enable) |=> (s_reg.hs | s_reg.ls) == 6'h00;
	endproperty
	a_ov_lockout: assert property (p_ov_lockout) else $error("driver on in lockout");

	property p_ov_recover;
		(!sense.ov && s_reg.supply_fail_flag && s_reg.overvoltage_lockout_enable) ##0 s_quiet
			|=> (s_reg.hs | s_reg.ls) == s_reg.en;
	endproperty
	a_ov_recover: assert property (p_ov_recover) else $error("no auto recovery");

	property p_ov_no_lock;
		(sense.ov && !s_reg.overvoltage_lockout_enable && !sense.tsd[0] && !sense.oc[0]) ##0 s_quiet
			|=> (s_reg.hs[0] | s_reg.ls[0]) == s_reg.en[0];
	endproperty
	a_ov_no_lock: assert property (p_ov_no_lock) else $error("outputs changed");

	property p_oc_latch;
		(sense.oc[1] && s_reg.oc_cnt[1] == hbfp_pkg::OC_CNT_W'(hbfp_pkg::OC_CYC - 1))
			|=> s_reg.oc_lat[1] && !s_reg.hs[1] && !s_reg.ls[1] && !s_reg.en[1] && !s_reg.cfg[1];
	endproperty
	a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");

	property p_oc_report;
		s_reg.oc_lat[1] |-> frame[hbfp_pkg::FR_OCS] && bstat[3:2] == hbfp_pkg::BS_OC;
	endproperty
	a_oc_report: assert property (p_oc_report) else $error("overcurrent report wrong");

	property p_oc_hold;
		(s_reg.oc_lat[1] && !status_reset_request && enable_pin) |=> s_reg.oc_lat[1];
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag lost");

	property p_uld_timer;
		((|uld_cond) && s_reg.uld_cnt < hbfp_pkg::ULD_CNT_W'(hbfp_pkg::ULD_CYC))
			|=> s_reg.uld_cnt == $past(s_reg.uld_cnt) + 1'b1;
	endproperty
	a_uld_timer: assert property (p_uld_timer) else $error("underload timer stalled");

	property p_uld_off;
		(uld_fire && uld_cond[5] && s_reg.underload_shutdown_control)
			|=> s_reg.uld_off[5] && frame[hbfp_pkg::FR_ULD] && !s_reg.ls[5];
	endproperty
	a_uld_off: assert property (p_uld_off) else $error("underload shutdown missed");

	property p_tsd_hold;
		(sense.tsd[4] && status_reset_request) |=> s_reg.tsd_lat[4];
	endproperty
	a_tsd_hold: assert property (p_tsd_hold) else $error("hot bridge cleared");

	property p_tsd_window;
		s_cs_fall ##0 (serial_clk == s_reg.sclk_d) |=> tsd_so_oe &&
			(tsd_so_out == (|s_reg.tsd_lat));
	endproperty
	a_tsd_window: assert property (p_tsd_window) else $error("thermal window missing");

	property p_tsd_close;
		(serial_clk && !s_reg.sclk_d) |=> !tsd_so_oe;
	endproperty
	a_tsd_close: assert property (p_tsd_close) else $error("window not closed");

	// Warning flag tracks its sensors, underload holds, and enable low kills drivers.
	property p_tw_follows;
		(|sense.tw) |=> frame[hbfp_pkg::FR_TW];
	endproperty
	a_tw_follows: assert property (p_tw_follows) else $error("thermal warning missed");

	property p_tw_clears;
		!(|sense.tw) |=> !frame[hbfp_pkg::FR_TW];
	endproperty
	a_tw_clears: assert property (p_tw_clears) else $error("thermal warning stuck");

	property p_uld_hold;
		(frame[hbfp_pkg::FR_ULD] && !status_reset_request && enable_pin) |=> frame[hbfp_pkg::FR_ULD];
	endproperty
	a_uld_hold: assert property (p_uld_hold) else $error("underload flag lost");

	property p_enable_off;
		!enable_pin |=> (s_reg.hs | s_reg.ls) == 6'h00;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("driver on with enable low");

endmodule

/* File: hbfp_mcu_model.sv */
// Microcontroller model: an Avalon-MM master that issues command words and status reads.
`timescale 1ns/1ps

module hbfp_mcu_model (
	input  wire logic        clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic      [3:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic      [3:0]  avs_byteenable
);
	// ---------------------------------------------------------------
	// Bus cycles
	// ---------------------------------------------------------------
	int timeouts;

	// The bus idles from time zero so nothing is requested while reset is held.
	initial begin
		timeouts = 0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
	end

	// One transfer, held until waitrequest is sampled low; a missing answer is
	// counted instead of hanging the caller, so the bench can end the run.
	task automatic access(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		if (avs_waitrequest !== 1'b0) timeouts++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the half-bridge fault protection block.
`timescale 1ns/1ps

module tb_top;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	logic                  clk;
	logic                  reset;
	logic [3:0]            avs_address;
	logic                  avs_read;
	logic                  avs_write;
	logic [31:0]           avs_writedata;
	logic [3:0]            avs_byteenable;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	hbfp_pkg::hbfp_sense_t sense;
	logic                  enable_pin;
	logic                  chip_select_n;
	logic                  serial_clk;
	logic                  tsd_so_out;
	logic                  tsd_so_oe;
	logic [5:0]            hs_on;
	logic [5:0]            ls_on;
	int                    fail_count;
	int                    check_count;

	hbfp_core uut (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sense(sense),
		.enable_pin(enable_pin), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
		.tsd_so_out(tsd_so_out), .tsd_so_oe(tsd_so_oe), .hs_on(hs_on), .ls_on(ls_on));

	hbfp_mcu_model mcu (.clk(clk), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

	// 10 MHz clock.
	always #50 clk = ~clk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Verdict and end of run; every path that stops the bench comes here.
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Command word: reset request, underload shutdown, config, enables, lockout enable.
	function automatic logic [15:0] cmd(input logic ov, input logic [5:0] en,
		input logic [5:0] cf, input logic ul, input logic status_reset_request);
		return {status_reset_request, 1'b0, ul, cf, en, ov};
	endfunction

	// A bus answer that never came counts as a mismatch and ends the run.
	task automatic bus_ok();
		if (mcu.timeouts != 0) begin
			fail_count++;
			$display("[FAIL] %0t bus answer missing", $time);
			stop_test();
		end
	endtask

	task automatic wr(input logic [15:0] c);
		logic [31:0] q;
		mcu.access(1'b1, hbfp_pkg::OFS_CMD, {16'h0000, c}, q);
		bus_ok();
	endtask

	// Reads a register and compares the bits under the mask.
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		mcu.access(1'b0, a, 32'h0, q);
		bus_ok();
		chk(q & m, e, "register read");
	endtask

	// Drivers are registered, so give the cause a few cycles to land.
	task automatic drv(input logic [5:0] hs, input logic [5:0] ls);
		cyc(3);
		chk({20'h0, hs_on, ls_on}, {20'h0, hs, ls}, "driver gates");
	endtask

	// Watchdog: a hang counts as a mismatch.
	initial begin
		#5000000;
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		stop_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	// Bridges 0, 2, 4 on the high side and 1, 3, 5 on the low side, until the thermal test leaves bridge 4 off.
	initial begin
		clk = 1'b0;
		reset = 1'b1;
		sense = '0;
		enable_pin = 1'b1;
		chip_select_n = 1'b1;
		serial_clk = 1'b0;
		fail_count = 0;
		check_count = 0;
		cyc(6);
		reset <= 1'b0;
		drv(6'h00, 6'h00);
		rd(hbfp_pkg::OFS_STATUS, 32'hFFFF, 32'h0);
		rd(4'h2, 32'hFFFFFFFF, 32'h0);
		// The lockout enable is kept set, as the controller should.
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b0, 1'b0));
		drv(6'h15, 6'h2A);
		$display("reset and command test done");

		sense.ov <= 1'b1;
		drv(6'h00, 6'h00);
		rd(hbfp_pkg::OFS_STATUS, 32'h7FFE, 32'h4000 | (32'h3F << 7) | (32'h15 << 1));
		sense.ov <= 1'b0;
		drv(6'h15, 6'h2A);
		rd(hbfp_pkg::OFS_STATUS, 32'h4000, 32'h0);
		wr(cmd(1'b0, 6'h3F, 6'h15, 1'b0, 1'b0));
		sense.ov <= 1'b1;
		drv(6'h15, 6'h2A);
		rd(hbfp_pkg::OFS_STATUS, 32'h4000, 32'h4000);
		sense.ov <= 1'b0;
		sense.tw[2] <= 1'b1;
		drv(6'h15, 6'h2A);
		rd(hbfp_pkg::OFS_STATUS, 32'h1, 32'h1);
		sense.tw[2] <= 1'b0;
		cyc(3);
		rd(hbfp_pkg::OFS_STATUS, 32'h1, 32'h0);
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b0, 1'b0));
		$display("supply and warning test done");

		// A short overcurrent must not trip; a long one latches that output off.
		sense.oc[1] <= 1'b1;
		cyc(90);
		sense.oc[1] <= 1'b0;
		rd(hbfp_pkg::OFS_FAULT, 32'h3F00, 32'h0);
		sense.oc[1] <= 1'b1;
		cyc(110);
		sense.oc[1] <= 1'b0;
		drv(6'h15, 6'h28);
		rd(hbfp_pkg::OFS_STATUS, 32'h9F80, 32'h8000 | (32'h3D << 7));
		rd(hbfp_pkg::OFS_BSTAT, 32'hC, 32'h4);
		wr(cmd(1'b1, 6'h3D, 6'h15, 1'b0, 1'b0));
		rd(hbfp_pkg::OFS_STATUS, 32'h8000, 32'h8000);
		wr(cmd(1'b1, 6'h3D, 6'h15, 1'b0, 1'b1));
		rd(hbfp_pkg::OFS_STATUS, 32'h8000, 32'h0);
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b0, 1'b0));
		drv(6'h15, 6'h2A);
		// A reset request while the overcurrent persists must not clear it.
		sense.oc[3] <= 1'b1;
		cyc(110);
		wr(cmd(1'b1, 6'h37, 6'h15, 1'b0, 1'b1));
		cyc(3);
		rd(hbfp_pkg::OFS_FAULT, 32'h3F00, 32'h0800);
		sense.oc[3] <= 1'b0;
		wr(cmd(1'b1, 6'h37, 6'h15, 1'b0, 1'b1));
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b0, 1'b0));
		$display("overcurrent test done");

		// Bridge 3 joins late on the shared timer and trips with bridge 5.
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b1, 1'b0));
		sense.underload_flag[5] <= 1'b1;
		cyc(3000);
		sense.underload_flag[3] <= 1'b1;
		cyc(600);
		sense.underload_flag <= '0;
		rd(hbfp_pkg::OFS_FAULT, 32'h3F3F0000, 32'h28280000);
		drv(6'h15, 6'h02);
		rd(hbfp_pkg::OFS_STATUS, 32'h2000, 32'h2000);
		rd(hbfp_pkg::OFS_BSTAT, 32'hCC0, 32'h880);
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b0, 1'b1));
		rd(hbfp_pkg::OFS_STATUS, 32'h2000, 32'h0);
		wr(cmd(1'b1, 6'h3F, 6'h15, 1'b0, 1'b0));
		drv(6'h15, 6'h2A);
		$display("underload test done");

		sense.tsd[4] <= 1'b1;
		drv(6'h05, 6'h2A);
		rd(hbfp_pkg::OFS_BSTAT, 32'h300, 32'h300);
		chip_select_n <= 1'b0;
		cyc(2);
		chk({30'h0, tsd_so_oe, tsd_so_out}, 32'h3, "serial window open");
		serial_clk <= 1'b1;
		cyc(3);
		chk({31'h0, tsd_so_oe}, 32'h0, "serial window closed");
		chip_select_n <= 1'b1;
		serial_clk <= 1'b0;
		wr(cmd(1'b1, 6'h2F, 6'h05, 1'b0, 1'b1));
		rd(hbfp_pkg::OFS_FAULT, 32'h3F, 32'h10);
		sense.tsd[4] <= 1'b0;
		wr(cmd(1'b1, 6'h2F, 6'h05, 1'b0, 1'b1));
		rd(hbfp_pkg::OFS_FAULT, 32'h3F, 32'h0);
		$display("thermal shutdown test done");

		sense.tsd[0] <= 1'b1;
		cyc(3);
		sense.tsd[0] <= 1'b0;
		rd(hbfp_pkg::OFS_FAULT, 32'h3F, 32'h1);
		enable_pin <= 1'b0;
		drv(6'h00, 6'h00);
		enable_pin <= 1'b1;
		rd(hbfp_pkg::OFS_FAULT, 32'hFFFFFFFF, 32'h0);
		$display("enable pin test done");

		// A reset in mid-run clears a latched fault and every command bit.
		sense.tsd[0] <= 1'b1;
		cyc(2);
		sense.tsd[0] <= 1'b0;
		rd(hbfp_pkg::OFS_FAULT, 32'h3F, 32'h1);
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		rd(hbfp_pkg::OFS_FAULT, 32'hFFFFFFFF, 32'h0);
		rd(hbfp_pkg::OFS_CMD, 32'hFFFF, 32'h0);
		drv(6'h00, 6'h00);
		$display("power-on reset test done");
		stop_test();
	end
endmodule
